/* rfd_cfg.sv */
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "rfd_regs.svh"
module rfd_cfg
    import rfd_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [`RFD_ADDR_W-1:0] reg_addr,
    input wire logic reg_space_b,
    input wire logic [`RFD_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`RFD_DATA_W-1:0] reg_rdata,
    input wire logic rf_period_pin,
    input wire logic [3:0] measured_ratio,
    input wire logic resistive_am_enable,
    output logic [2:0] driver_timing,
    output logic cal_busy,
    output logic [2:0] peer_threshold,
    output logic [3:0] collision_threshold,
    output logic minimum_nonoverlap_select,
    output logic [6:0] modulated_resistance_code,
    output logic modulated_resistance_apply
);
    logic [7:0] tim_r;
    logic [7:0] thr_r;
    logic [7:0] am_r;
    logic [7:0] rdata_r;
    logic [2:0] sync_r;
    logic rf_lvl_r;
    rfd_cal_state_t st_r;
    rfd_cal_state_t st_nxt;
    rfd_speed_t step_r;
    rfd_speed_t step_nxt;
    rfd_speed_t acq_r;
    rfd_speed_t acq_nxt;
    logic [2:0] drv_r;
    logic busy_r;
    logic [2:0] peer_r;
    logic [3:0] coll_r;
    logic minnov_r;
    logic [6:0] code_r;
    logic apply_r;
    logic [7:0] tim_nxt;
    logic [7:0] thr_nxt;
    logic [7:0] am_nxt;
    logic [7:0] rdata_nxt;
    logic [2:0] drv_nxt;
    logic busy_nxt;
    logic [2:0] peer_nxt;
    logic [3:0] coll_nxt;
    logic minnov_nxt;
    logic [6:0] code_nxt;
    logic apply_nxt;
    logic [2:0] sync_nxt;
    logic rf_lvl_nxt;

    function automatic rfd_speed_t man_decode(input logic [2:0] c);
        rfd_speed_t s;
        s = RFD_FAST;
        if (!c[2]) begin
            case (c[1:0])
                2'h0: s = RFD_SLOW;
                2'h1: s = RFD_MED_SLOW;
                2'h2: s = RFD_NOMINAL;
                default: s = RFD_MED_FAST;
            endcase
        end
        return s;
    endfunction

    // space and offset compare for one register
    function automatic logic reg_hit(
        input logic space_b,
        input logic [7:0] addr,
        input logic want_b,
        input logic [7:0] ofs
    );
        return space_b == want_b && addr == ofs;
    endfunction

    // address decode
    wire sel_tim = reg_hit(reg_space_b, reg_addr, 1'b1,
        `RFD_OFS_TX_DRIVER_TIMING);
    wire sel_thr = reg_hit(reg_space_b, reg_addr, 1'b0,
        `RFD_OFS_FIELD_DETECT_THRESHOLDS);
    wire sel_am = reg_hit(reg_space_b, reg_addr, 1'b1,
        `RFD_OFS_RESISTIVE_AM_SETTING);
    wire sel_cal = reg_hit(reg_space_b, reg_addr, 1'b1,
        `RFD_OFS_CAL_CONTROL);

    // write enables
    wire wr_tim = reg_wr && sel_tim;
    wire wr_thr = reg_wr && sel_thr;
    wire wr_am = reg_wr && sel_am;
    wire cal_start = reg_wr && sel_cal && reg_wdata[`RFD_CAL_START_BIT];

    // search target and timing source
    wire [3:0] target = tim_r[`RFD_TIM_RATIO_HI:`RFD_TIM_RATIO_LO];
    wire manual = tim_r[`RFD_TIM_MANUAL_BIT];
    wire rf_agree = sync_r[1] == sync_r[2];
    wire rf_tick = rf_agree && sync_r[2] && !rf_lvl_r;
    wire [7:0] cal_status = {busy_r, 4'h0, acq_r};
    wire [7:0] rd_mux = sel_tim ? tim_r :
                        sel_thr ? thr_r :
                        sel_am ? am_r :
                        sel_cal ? cal_status : 8'h00;
    wire rfd_speed_t applied = manual
        ? man_decode(tim_r[`RFD_TIM_CODE_HI:0])
        : acq_r;
    wire [6:0] code_eff = resistive_am_enable
        ? am_r[`RFD_AM_CODE_HI:0] : 7'h00;

    // next values of the register bank
    assign tim_nxt = wr_tim ? reg_wdata : tim_r;
    assign thr_nxt = wr_thr ? {1'b0, reg_wdata[6:0]} : thr_r;
    assign am_nxt = wr_am ? reg_wdata : am_r;

    // rf carrier edge, second and third flop agree
    assign sync_nxt = {sync_r[1:0], rf_period_pin};
    assign rf_lvl_nxt = rf_agree ? sync_r[2] : rf_lvl_r;

    // next values of the outputs
    assign rdata_nxt = reg_rd ? rd_mux : 8'h00;
    assign drv_nxt = (st_r == RFD_IDLE) ? applied : step_r;
    assign busy_nxt = st_nxt != RFD_IDLE;
    assign peer_nxt = thr_r[`RFD_THR_PEER_HI:`RFD_THR_PEER_LO];
    assign coll_nxt = thr_r[`RFD_THR_COLL_HI:0];
    assign minnov_nxt = am_r[`RFD_AM_MINNOV_BIT];
    assign code_nxt = code_eff;
    assign apply_nxt = resistive_am_enable;

    // calibration search sequencer
    always_comb begin
        st_nxt = st_r;
        step_nxt = step_r;
        acq_nxt = acq_r;
        case (st_r)
            RFD_IDLE: begin
                if (cal_start) begin
                    step_nxt = RFD_SLOW;
                    st_nxt = RFD_SETTLE;
                end
            end
            RFD_SETTLE: begin
                if (rf_tick) begin
                    st_nxt = RFD_MEASURE;
                end
            end
            RFD_MEASURE: begin
                if (rf_tick) begin
                    if (measured_ratio >= target) begin
                        acq_nxt = step_r;
                        st_nxt = RFD_IDLE;
                    end else if (step_r == RFD_FAST) begin
                        acq_nxt = step_r;
                        st_nxt = RFD_IDLE;
                    end else begin
                        step_nxt = rfd_speed_t'(step_r + 3'h1);
                        st_nxt = RFD_SETTLE;
                    end
                end
            end
            default: begin
                st_nxt = RFD_IDLE;
            end
        endcase
    end

    // pin synchroniser
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sync_r <= 3'h0;
        end else begin
            sync_r <= sync_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rf_lvl_r <= 1'b0;
        end else begin
            rf_lvl_r <= rf_lvl_nxt;
        end
    end

    // register bank
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tim_r <= `RFD_RST_TX_DRIVER_TIMING;
        end else begin
            tim_r <= tim_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            thr_r <= `RFD_RST_FIELD_DETECT_THRESHOLDS;
        end else begin
            thr_r <= thr_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            am_r <= `RFD_RST_RESISTIVE_AM_SETTING;
        end else begin
            am_r <= am_nxt;
        end
    end

    // sequencer state
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_r <= RFD_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            step_r <= RFD_SLOW;
        end else begin
            step_r <= step_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            acq_r <= RFD_SLOW;
        end else begin
            acq_r <= acq_nxt;
        end
    end

    // output flops
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            drv_r <= 3'h0;
        end else begin
            drv_r <= drv_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= busy_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            peer_r <= 3'h0;
        end else begin
            peer_r <= peer_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            coll_r <= 4'h0;
        end else begin
            coll_r <= coll_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            minnov_r <= 1'b0;
        end else begin
            minnov_r <= minnov_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            code_r <= 7'h00;
        end else begin
            code_r <= code_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            apply_r <= 1'b0;
        end else begin
            apply_r <= apply_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign driver_timing = drv_r;
    assign cal_busy = busy_r;
    assign peer_threshold = peer_r;
    assign collision_threshold = coll_r;
    assign minimum_nonoverlap_select = minnov_r;
    assign modulated_resistance_code = code_r;
    assign modulated_resistance_apply = apply_r;
endmodule

/* rfd_cfg_checker.sv */
`timescale 1ns/1ps
module rfd_cfg_checker (
    input logic core_clk,
    input logic reset,
    input logic [7:0] reg_addr,
    input logic reg_space_b,
    input logic [7:0] reg_wdata,
    input logic reg_wr,
    input logic resistive_am_enable,
    input logic [2:0] driver_timing,
    input logic cal_busy,
    input logic [2:0] peer_threshold,
    input logic [3:0] collision_threshold,
    input logic minimum_nonoverlap_select,
    input logic [6:0] modulated_resistance_code,
    input logic modulated_resistance_apply
);
    localparam int CAL_MAX = 120;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    wire hit = reg_wr && reg_addr == 8'h2a;
    wire wa = hit && !reg_space_b;
    wire wb = hit && reg_space_b;
    wire wt = reg_wr && reg_space_b && reg_addr == 8'h29;
    wire man = wt && reg_wdata[3] && !cal_busy;
    peer_map_a: assert property (wa |-> ##2
        peer_threshold == $past(reg_wdata[6:4], 2)) else $error("peer");
    coll_map_a: assert property (wa |-> ##2
        collision_threshold == $past(reg_wdata[3:0], 2)) else $error("coll");
    min_nonoverlap_a: assert property (wb |-> ##2
        minimum_nonoverlap_select == $past(reg_wdata[7], 2)) else $error("mn");
    code_map_a: assert property (wb ##1 resistive_am_enable |-> ##1
        modulated_resistance_code == $past(reg_wdata[6:0], 2)) else $error("c");
    code_gate_a: assert property (!modulated_resistance_apply |->
        modulated_resistance_code == 7'h0) else $error("gate");
    apply_follow_a: assert property (modulated_resistance_apply ==
        $past(resistive_am_enable)) else $error("apply");
    manual_decode_a: assert property (man |-> ##2 driver_timing ==
        ($past(reg_wdata[2], 2) ? 3'h4 : $past(reg_wdata, 2) & 3'h3))
        else $error("decode");
    cal_start_a: assert property ($rose(cal_busy) |-> ##1
        driver_timing == 3'h0) else $error("start");
    step_order_a: assert property (cal_busy && $past(cal_busy, 3) |->
        driver_timing - $past(driver_timing) <= 3'h1) else $error("step");
    cal_bound_a: assert property ($rose(cal_busy) |->
        ##[1:CAL_MAX] !cal_busy) else $error("bound");
    cover property ($fell(cal_busy));
    cover property (cal_busy && driver_timing == 3'h4);
    cover property (modulated_resistance_code != 7'h0);
endmodule

/* rfd_pkg.sv */
package rfd_pkg;
    typedef enum logic [2:0] {
        RFD_SLOW,
        RFD_MED_SLOW,
        RFD_NOMINAL,
        RFD_MED_FAST,
        RFD_FAST
    } rfd_speed_t;
    typedef enum logic [1:0] {
        RFD_IDLE,
        RFD_SETTLE,
        RFD_MEASURE
    } rfd_cal_state_t;
endpackage

/* rfd_regs.svh */
`ifndef RFD_REGS_SVH
`define RFD_REGS_SVH

`define RFD_ADDR_W 8
`define RFD_DATA_W 8
`define RFD_OFS_TX_DRIVER_TIMING 8'h29
`define RFD_OFS_FIELD_DETECT_THRESHOLDS 8'h2a
`define RFD_OFS_RESISTIVE_AM_SETTING 8'h2a
`define RFD_OFS_CAL_CONTROL 8'h2b
`define RFD_RST_TX_DRIVER_TIMING 8'h7c
`define RFD_RST_FIELD_DETECT_THRESHOLDS 8'h33
`define RFD_RST_RESISTIVE_AM_SETTING 8'h00
`define RFD_TIM_RATIO_HI 7
`define RFD_TIM_RATIO_LO 4
`define RFD_TIM_MANUAL_BIT 3
`define RFD_TIM_CODE_HI 2
`define RFD_THR_PEER_HI 6
`define RFD_THR_PEER_LO 4
`define RFD_THR_COLL_HI 3
`define RFD_AM_MINNOV_BIT 7
`define RFD_AM_CODE_HI 6
`define RFD_CAL_START_BIT 0
`define RFD_CAL_STEPS 5
`define RFD_CAL_MAX_PERIODS 10
`define RFD_CAL_PERIODS_PER_STEP 2
`endif

/* test_rfd_cfg.sv */
`timescale 1ns/1ps
module test_rfd_cfg;
    logic core_clk = 0, reset = 1, reg_space_b = 0, reg_wr = 0, reg_rd = 0;
    logic rf_period_pin = 0, resistive_am_enable = 0, cal_busy;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, v;
    logic [3:0] measured_ratio = 0, collision_threshold, a;
    logic [2:0] driver_timing, peer_threshold;
    logic minimum_nonoverlap_select, modulated_resistance_apply;
    logic [6:0] modulated_resistance_code;
    logic [3:0] tg[5] = '{4'h0, 4'h5, 4'h9, 4'hc, 4'hf};
    int n_errors = 0, n_compared = 0, cyc = 0;
    rfd_cfg dut_u (.*);
    always #50 core_clk = ~core_clk;
    always #397 rf_period_pin = ~rf_period_pin;
    always @(posedge core_clk) begin
        measured_ratio <= 4'(driver_timing * 3);
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_errors++;
            close_out;
        end
    end
    task chk(input logic [7:0] got, exp, input string w);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s exp %h got %h", w, exp, got);
        end
    endtask
    task wr(input logic b, input logic [7:0] ad, d);
        @(posedge core_clk);
        {reg_space_b, reg_addr, reg_wdata, reg_wr} <= {b, ad, d, 1'b1};
        @(posedge core_clk);
        reg_wr <= 0;
    endtask
    task rd(input logic b, input logic [7:0] ad, x, input string w);
        @(posedge core_clk);
        {reg_space_b, reg_addr, reg_rd} <= {b, ad, 1'b1};
        @(posedge core_clk);
        reg_rd <= 0;
        @(negedge core_clk);
        chk(reg_rdata, x, w);
    endtask
    function logic [2:0] acq(logic [3:0] t);
        for (int s = 0; s < 4; s++)
            if (s * 3 >= t) return 3'(s);
        return 3'h4;
    endfunction
    task close_out;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        void'($urandom(32'ha631));
        repeat (20) @(posedge core_clk);
        reset <= 0;
        repeat (3) @(negedge core_clk);
        chk(driver_timing, 3'h4, "tim");
        chk({peer_threshold, collision_threshold}, 7'h33, "thr");
        rd(1, 8'h29, 8'h7c, "tim");
        rd(0, 8'h2a, 8'h33, "thr");
        rd(1, 8'h2a, 8'h00, "am");
        $display("reset test done");
        for (int i = 0; i < 24; i++) begin
            v = i == 0 ? 8'hff : i == 1 ? 8'h00 : 8'($urandom);
            @(posedge core_clk);
            resistive_am_enable <= v[0];
            wr(0, 8'h2a, v);
            wr(1, 8'h2a, v);
            wr(1, 8'h29, {v[7:4], 1'b1, 3'(i)});
            repeat (2) @(negedge core_clk);
            chk(driver_timing, i[2] ? 3'h4 : 3'(i), "man");
            chk(modulated_resistance_code, v[0] ? v[6:0] : 7'h0, "c");
            chk(minimum_nonoverlap_select, v[7], "mn");
            rd(0, 8'h2a, v & 8'h7f, "thr");
            rd(1, 8'h2a, v, "am");
        end
        wr(0, 8'h55, 8'hff);
        rd(0, 8'h55, 8'h00, "unmapped");
        rd(0, 8'h29, 8'h00, "space");
        $display("register test done");
        foreach (tg[k]) begin
            a = acq(tg[k]);
            wr(1, 8'h29, {tg[k], 4'h0});
            wr(1, 8'h2b, 8'h01);
            repeat (3) @(negedge core_clk);
            chk(cal_busy, 1'b1, "busy");
            for (int w = 0; w < 200 && cal_busy !== 1'b0; w++)
                @(negedge core_clk);
            @(negedge core_clk);
            chk(driver_timing, a, "acq");
            rd(1, 8'h2b, {5'h0, a}, "stat");
        end
        $display("calibration test done");
        close_out;
    end
endmodule
bind rfd_cfg rfd_cfg_checker chk_u (.*);
